// ---- blrst_core.sv ----
`timescale 1ns/1ps
`include "blrst_cfg.svh"
module blrst_core #(
	parameter int START_CYC = `BLRST_START_DELAY_CYC  // Start-up wait, cycles
) (
	input  wire logic       core_clk_i,      // Core clock, 100 MHz
	input  wire logic       reset_n_i,       // Sync reset, active low
	input  wire logic       cyc_start_i,     // Start a bus cycle, pulse
	input  wire logic [2:0] cyc_beats_i,     // Extra beats (0 = non-burst)
	input  wire logic       hold_req_i,      // Bus hold request pin
	input  wire logic       burst_ready_n_i, // Burst-ready pin, active low
	input  wire logic       ready_n_i,       // Non-burst-ready pin, active low
	output logic            last_transfer_n_o,  // Last-transfer out, active low
	output logic            last_transfer_oe_o, // Output enable, high drives
	output logic            hold_ack_o,      // Bus granted to other master
	output logic            cyc_done_o,      // Cycle completed, pulse
	output logic            exec_ok_o        // Execution may start
);
	blrst_pkg::blrst_state_e state_q;        // Sequencer state
	blrst_pkg::blrst_beat_t  beats_q;        // Beats remaining after current
	logic [`BLRST_CNT_W-1:0] start_cnt_q;    // Start-up delay counter
	logic                    hold_s;         // Synchronised hold request
	logic                    burst_rdy_s;    // Synchronised burst-ready (low active)
	logic                    rdy_s;          // Synchronised non-burst-ready
	logic                    burst_hit;      // Burst-ready accepted this clock
	logic                    rdy_hit;        // Non-burst-ready accepted
	logic                    end_cyc;        // Cycle ends this clock
	logic [`BLRST_CNT_W-1:0] since_rst_q;    // Cycles since reset, checks only

	// Pin synchronisers
	blrst_sync #(.RESET_VAL(1'b0)) u_hold (
		.core_clk_i (core_clk_i),
		.reset_n_i  (reset_n_i),
		.async_i    (hold_req_i),
		.sync_o     (hold_s)
	);
	blrst_sync #(.RESET_VAL(1'b1)) u_burst_rdy (
		.core_clk_i (core_clk_i),
		.reset_n_i  (reset_n_i),
		.async_i    (burst_ready_n_i),
		.sync_o     (burst_rdy_s)
	);
	blrst_sync #(.RESET_VAL(1'b1)) u_rdy (
		.core_clk_i (core_clk_i),
		.reset_n_i  (reset_n_i),
		.async_i    (ready_n_i),
		.sync_o     (rdy_s)
	);

	// Ready decode; both only count after first clock
	// first clock ignored
	always_comb begin
		burst_hit = (state_q == blrst_pkg::BLRST_DATA) && !burst_rdy_s;
		rdy_hit   = (state_q == blrst_pkg::BLRST_DATA) && !rdy_s;
		end_cyc   = rdy_hit || (burst_hit && beats_q == 3'h0);
	end

	// Start-up counter; held at zero throughout reset
	// 1 ms wait
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			start_cnt_q <= '0;
			exec_ok_o   <= 1'b0;
		end else if (!exec_ok_o) begin
			start_cnt_q <= start_cnt_q + `BLRST_CNT_W'(1);
			exec_ok_o   <= (start_cnt_q >= `BLRST_CNT_W'(START_CYC - 1));
		end
	end

	// Cycles since reset release, saturating; feeds the start-up check only
	// Kept apart from the start-up counter so a fault there cannot hide itself
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			since_rst_q <= '0;
		end else if (since_rst_q != '1) begin
			since_rst_q <= since_rst_q + `BLRST_CNT_W'(1);
		end
	end

	// Cycle sequencer
	// defined reset state
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			state_q <= blrst_pkg::BLRST_IDLE;
			beats_q <= 3'h0;
		end else begin
			unique case (state_q)
				blrst_pkg::BLRST_IDLE: begin
					// Hold wins over a new cycle
					if (hold_s)
						state_q <= blrst_pkg::BLRST_HOLD;
					else if (cyc_start_i && exec_ok_o) begin
						state_q <= blrst_pkg::BLRST_FIRST;
						beats_q <= cyc_beats_i;
					end
				end
				blrst_pkg::BLRST_FIRST: begin
					state_q <= blrst_pkg::BLRST_DATA;
				end
				blrst_pkg::BLRST_DATA: begin
					// Hold only granted between cycles
					if (end_cyc)
						state_q <= blrst_pkg::BLRST_IDLE;
					else if (burst_hit)
						beats_q <= beats_q - 3'h1;
				end
				blrst_pkg::BLRST_HOLD: begin
					if (!hold_s)
						state_q <= blrst_pkg::BLRST_IDLE;
				end
				default: state_q <= blrst_pkg::BLRST_IDLE;
			endcase
		end
	end

	// Pin drivers, registered from next state
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			last_transfer_n_o  <= 1'b1;
			last_transfer_oe_o <= 1'b1;
			hold_ack_o         <= 1'b0;
			cyc_done_o         <= 1'b0;
		end else begin
			cyc_done_o <= end_cyc;
			hold_ack_o         <= (state_q == blrst_pkg::BLRST_IDLE && hold_s) ||
			                      (state_q == blrst_pkg::BLRST_HOLD && hold_s);
			last_transfer_oe_o <= !((state_q == blrst_pkg::BLRST_IDLE && hold_s) ||
			                        (state_q == blrst_pkg::BLRST_HOLD && hold_s));
			if (state_q == blrst_pkg::BLRST_IDLE && !hold_s && cyc_start_i && exec_ok_o)
				last_transfer_n_o <= (cyc_beats_i != 3'h0);
			else if (state_q == blrst_pkg::BLRST_DATA && burst_hit && !end_cyc)
				last_transfer_n_o <= (beats_q != 3'h1);
			else if (end_cyc || state_q == blrst_pkg::BLRST_IDLE)
				last_transfer_n_o <= 1'b1;
		end
	end

	// Last low whenever a cycle waits on its final ready
	// low at final beat
	property p_last_final;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		(state_q == blrst_pkg::BLRST_DATA && beats_q == 3'h0) |-> !last_transfer_n_o;
	endproperty
	a_last_final: assert property (p_last_final) else $error("last not low at final beat");

	property p_single;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		(state_q == blrst_pkg::BLRST_IDLE && !hold_s && cyc_start_i && exec_ok_o &&
		 cyc_beats_i == 3'h0) |=> !last_transfer_n_o;
	endproperty
	a_single: assert property (p_single) else $error("single cycle lacks last");

	property p_idle_high;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		$rose(cyc_done_o) |-> last_transfer_n_o;
	endproperty
	a_idle_high: assert property (p_idle_high) else $error("last stays low after end");

	property p_float;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		hold_ack_o |-> !last_transfer_oe_o;
	endproperty
	a_float: assert property (p_float) else $error("last driven during hold");

	property p_reset;
		@(posedge core_clk_i)
		!reset_n_i |=> (state_q == blrst_pkg::BLRST_IDLE && !exec_ok_o && !cyc_done_o);
	endproperty
	a_reset: assert property (p_reset) else $error("reset state not defined");

	property p_no_early;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		exec_ok_o |-> start_cnt_q >= `BLRST_CNT_W'(START_CYC - 1);
	endproperty
	a_no_early: assert property (p_no_early) else $error("execution before delay");

	property p_abort;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		rdy_hit |=> (cyc_done_o && state_q == blrst_pkg::BLRST_IDLE);
	endproperty
	a_abort: assert property (p_abort) else $error("ready did not end cycle");

	property p_first_ignored;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		(state_q == blrst_pkg::BLRST_FIRST) |=> !cyc_done_o;
	endproperty
	a_first_ignored: assert property (p_first_ignored) else $error("ready on first clock");

	property p_done_pulse;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		cyc_done_o |=> !cyc_done_o;
	endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("done longer than one clock");

	property p_burst_last;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		(burst_hit && !end_cyc && beats_q == 3'h1) |=> !last_transfer_n_o;
	endproperty
	a_burst_last: assert property (p_burst_last) else $error("last late in burst");

	property p_hold_float;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		(state_q == blrst_pkg::BLRST_HOLD) |-> (!last_transfer_oe_o && hold_ack_o);
	endproperty
	a_hold_float: assert property (p_hold_float) else $error("hold state still drives");

	property p_drive_busy;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		(state_q == blrst_pkg::BLRST_FIRST || state_q == blrst_pkg::BLRST_DATA) |->
			last_transfer_oe_o;
	endproperty
	a_drive_busy: assert property (p_drive_busy) else $error("last floats in a cycle");

	property p_start_wait;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		$rose(exec_ok_o) |-> (since_rst_q == `BLRST_CNT_W'(START_CYC));
	endproperty
	a_start_wait: assert property (p_start_wait) else $error("start-up wait too short");
endmodule

// ---- blrst_cfg.svh ----
`ifndef BLRST_CFG_SVH
`define BLRST_CFG_SVH

// Core clock period in picoseconds (100 MHz)
`define BLRST_CLK_PERIOD_PS   32'd10000
// Least start-up delay after reset release, in microseconds
`define BLRST_START_DELAY_US  32'd1000
// Start-up delay in cycles, rounded up
`define BLRST_START_DELAY_CYC \
	((`BLRST_START_DELAY_US * 32'd1000000 + `BLRST_CLK_PERIOD_PS - 32'd1) / `BLRST_CLK_PERIOD_PS)
// Width of the start-up counter
`define BLRST_CNT_W           17
// Width of the burst beat counter
`define BLRST_BEAT_W          3

`endif

// ---- blrst_pkg.sv ----
package blrst_pkg;
	// Bus cycle sequencer states, one-hot
	typedef enum logic [3:0] {
		BLRST_IDLE  = 4'b0001,
		BLRST_FIRST = 4'b0010,
		BLRST_DATA  = 4'b0100,
		BLRST_HOLD  = 4'b1000
	} blrst_state_e;
	// Beat counter type
	typedef logic [2:0] blrst_beat_t;
endpackage

// ---- blrst_sync.sv ----
`timescale 1ns/1ps
// Two-stage synchroniser for pin inputs
module blrst_sync #(
	parameter logic RESET_VAL = 1'b1
) (
	input  wire logic core_clk_i,   // Core clock
	input  wire logic reset_n_i,    // Sync reset, active low
	input  wire logic async_i,      // Raw pin level
	output logic      sync_o        // Synchronised level
);
	logic meta_q;                   // First stage, read only by second

	// Two flops; first stage feeds nothing else
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			meta_q <= RESET_VAL;
			sync_o <= RESET_VAL;
		end else begin
			meta_q <= async_i;
			sync_o <= meta_q;
		end
	end
endmodule

// ---- blrst_ext_model.sv ----
`timescale 1ns/1ps
// Far-side bus controller
module blrst_ext_model (
	input  wire logic       core_clk_i,      // Core clock
	input  wire logic       serve_i,         // Answer transfers
	input  wire logic       abort_i,         // Also give ready_n
	input  wire logic [3:0] gap_i,           // Wait states
	output logic            burst_ready_n_o, // Burst-ready, pulled up
	output logic            ready_n_o        // Non-burst-ready
);
	logic [3:0] wait_q = 4'h0; // Wait counter
	logic       serve_q;       // Serve control, rising-edge copy
	logic       abort_q;       // Abort control, rising-edge copy
	logic [3:0] gap_q;         // Wait states, rising-edge copy
	// Controls copied on the rising edge; the bench writes them on the
	// falling edge, so reading them there would race the bench
	always @(posedge core_clk_i) begin
		serve_q <= serve_i;
		abort_q <= abort_i;
		gap_q   <= gap_i;
	end
	always @(negedge core_clk_i) begin
		// One-cycle strobes, pull-up level between them
		burst_ready_n_o <= !(serve_q && wait_q == gap_q);
		ready_n_o <= !(serve_q && abort_q && wait_q == gap_q);
		wait_q <= (!serve_q || wait_q == gap_q) ? 4'h0 : wait_q + 4'h1;
	end
endmodule

// ---- tb_top.sv ----
`timescale 1ns/1ps
// Bench for the last-transfer and reset block
module tb_top;
	localparam int SC = 20; // Short start-up wait
	logic core_clk_i, reset_n_i, cyc_start_i, hold_req_i;
	logic [2:0] cyc_beats_i;
	logic burst_rdy_n, rdy_n, last_n, oe, hack, done, exok;
	logic serve, abort;
	logic [3:0] gap;
	int n_mismatch = 0;
	int num_checks = 0;
	blrst_core #(.START_CYC(SC)) i_blrst_core (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
		.cyc_start_i(cyc_start_i), .cyc_beats_i(cyc_beats_i), .hold_req_i(hold_req_i),
		.burst_ready_n_i(burst_rdy_n), .ready_n_i(rdy_n), .last_transfer_n_o(last_n),
		.last_transfer_oe_o(oe), .hold_ack_o(hack), .cyc_done_o(done), .exec_ok_o(exok));
	blrst_ext_model i_blrst_ext_model (.core_clk_i(core_clk_i), .serve_i(serve),
		.abort_i(abort), .gap_i(gap), .burst_ready_n_o(burst_rdy_n), .ready_n_o(rdy_n));
	// Clock, 10 ns
	initial begin
		core_clk_i = 1'b0;
		forever #5 core_clk_i = ~core_clk_i;
	end
	task automatic chk(input logic e, input logic g);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// Start pulse; returns where last_n has settled
	task automatic start(input logic [2:0] b);
		@(negedge core_clk_i);
		cyc_start_i = 1'b1;
		cyc_beats_i = b;
		@(negedge core_clk_i);
		cyc_start_i = 1'b0;
	endtask
	// Bounded wait for done, noting any low last_n
	task automatic wait_done(output int n, output logic lo);
		n = 0;
		lo = 1'b0;
		while (done !== 1'b1 && n < 40) begin
			lo |= (last_n === 1'b0);
			@(negedge core_clk_i);
			n++;
		end
	endtask
	// Reset, even mid-cycle, then start-up wait
	task automatic t_reset;
		int n;
		@(negedge core_clk_i);
		reset_n_i = 1'b0;
		repeat (3) @(negedge core_clk_i);
		chk(1'b1, last_n);
		chk(1'b0, exok);
		// Release with an early request, which must be dropped
		reset_n_i = 1'b1;
		cyc_start_i = 1'b1;
		cyc_beats_i = 3'h0;
		@(negedge core_clk_i);
		cyc_start_i = 1'b0;
		n = 1;
		chk(1'b1, last_n);
		while (exok !== 1'b1 && n < 40) begin
			@(negedge core_clk_i);
			n++;
		end
		chk(1'b1, 1'(n == SC));
		$display("t_reset ended");
	endtask
	task automatic t_cycle(input logic [2:0] b, input logic ab, input int lim);
		int n;
		logic lo;
		serve = 1'b1;
		abort = ab;
		start(b);
		chk(b != 3'h0, last_n);
		wait_done(n, lo);
		chk(1'b1, 1'(n < lim));
		// An aborted burst never reaches its final beat, so last stays high
		chk(!ab || b == 3'h0, lo);
		@(negedge core_clk_i);
		chk(1'b1, last_n);
		chk(1'b0, done);
		serve = 1'b0;
		abort = 1'b0;
		repeat (6) @(negedge core_clk_i);
		$display("t_cycle ended");
	endtask
	task automatic t_hold;
		hold_req_i = 1'b1;
		repeat (5) @(negedge core_clk_i);
		chk(1'b1, hack);
		chk(1'b0, oe);
		start(3'h0);
		chk(1'b1, last_n);
		hold_req_i = 1'b0;
		repeat (5) @(negedge core_clk_i);
		chk(1'b1, oe);
		chk(1'b0, hack);
		$display("t_hold ended");
	endtask
	// Watchdog, far beyond the hundred or so cycles needed
	initial begin
		#20000;
		n_mismatch++;
		tally_and_finish;
	end
	initial begin
		{reset_n_i, cyc_start_i, hold_req_i, serve, abort} = 5'h00;
		cyc_beats_i = 3'h0;
		gap = 4'h2;
		t_reset;
		t_cycle(3'h0, 1'b0, 20);
		t_cycle(3'h1, 1'b0, 30);
		gap = 4'h3;
		t_cycle(3'h3, 1'b1, 11);
		t_hold;
		serve = 1'b1;
		start(3'h3);
		t_reset;
		serve = 1'b0;
		tally_and_finish;
	end
endmodule
